/* rtl/smbus_timing_params.svh */
// timing constants for the setup/hold and start-detect window block
`ifndef SMBUS_TIMING_PARAMS_SVH
`define SMBUS_TIMING_PARAMS_SVH
`define SETUP_STD_CYC   6'h0_00B
`define HOLD_STD_CYC    6'h0_00C
`define SETUP_EXT_CYC   6'h0_01F
`define HOLD_EXT_CYC    6'h0_01F
`define SETUP_BASE_CYC  6'h0_001
`define HOLD_BASE_CYC   6'h0_001
`define WIN_NONE_CYC    4'h0_0
`define WIN_TWO_CYC     4'h0_2
`define WIN_MID_CYC     4'h0_5
`define WIN_EIGHT_CYC   4'h0_8
`define WIN_CODE_NONE   2'h0
`define WIN_CODE_TWO    2'h1
`define WIN_CODE_MID    2'h2
`define WIN_CODE_EIGHT  2'h3
`endif

/* rtl/smbus_timing_pkg.sv */
// types for the setup/hold and start-detect window block
package smbus_timing_pkg;
  typedef enum logic [1:0] {
    WIN_NONE,
    WIN_PLUS_TWO,
    WIN_MID,
    WIN_PLUS_EIGHT
  } win_code_e;
  typedef enum logic [1:0] {
    SDA_IDLE,
    SDA_SETUP,
    SDA_HOLD
  } sda_state_e;
endpackage : smbus_timing_pkg

/* rtl/smbus_setup_hold_start_window.sv */
// sda setup/hold stretching and start-detect window, on the system clock
// How it works
// (R1) stretch select only matters while the extension enable is one
// (R2) extension on, select zero: sda setup 11 cycles, hold 12 cycles
// (R3) extension on, select one: sda setup 31 and hold 31 cycles
// (R4) window code zero adds no delay, sda fall seen in 0-1 cycles
// (R5) code one widens window to 2-3 cycles, code three to 8-9 cycles
// (R6) scl fall inside window after sda fall is not taken as start
// (R7) software should leave the window code at zero unless lines are heavy
// (R8) code two gives a window between codes one and three
`timescale 1ns/1ps
`include "smbus_timing_params.svh"
module smbus_setup_hold_start_window (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       setup_hold_extension_enable,
  input  wire logic       hold_delay_stretch_select,
  input  wire logic [1:0] start_detect_window,
  input  wire logic       sda_out_req,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe_n,
  output logic            sda_busy,
  output logic            start_seen
);
  logic       rst_meta_q, rst_sync_q;
  logic       scl_m_q, scl_s_q, scl_prev_q;
  logic       sda_m_q, sda_s_q, sda_prev_q;
  logic       sda_drv_q;
  logic       start_q;
  logic [5:0] cnt_q;
  logic [3:0] win_q;
  logic       pend_q;
  smbus_timing_pkg::sda_state_e st_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      scl_m_q    <= 1'b1;
      scl_s_q    <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_m_q    <= 1'b1;
      sda_s_q    <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (clk_en) begin
      scl_m_q    <= scl_in;
      scl_s_q    <= scl_m_q;
      scl_prev_q <= scl_s_q;
      sda_m_q    <= sda_in;
      sda_s_q    <= sda_m_q;
      sda_prev_q <= sda_s_q;
    end
  end

  wire scl_fall = scl_prev_q & ~scl_s_q;
  wire scl_rise = ~scl_prev_q & scl_s_q;
  wire sda_fall = sda_prev_q & ~sda_s_q;

  // extension select is ignored unless the extension enable is set
  wire       ext_on    = setup_hold_extension_enable;               // R1
  wire       ext_long  = ext_on & hold_delay_stretch_select;         // R1
  wire [5:0] setup_cyc = !ext_on  ? `SETUP_BASE_CYC :
                         ext_long ? `SETUP_EXT_CYC : `SETUP_STD_CYC; // R2 R3
  wire [5:0] hold_cyc  = !ext_on  ? `HOLD_BASE_CYC :
                         ext_long ? `HOLD_EXT_CYC : `HOLD_STD_CYC;   // R2 R3

  function automatic logic [3:0] win_len(input logic [1:0] code);
    case (code)
      `WIN_CODE_TWO:   win_len = `WIN_TWO_CYC;
      `WIN_CODE_MID:   win_len = `WIN_MID_CYC;
      `WIN_CODE_EIGHT: win_len = `WIN_EIGHT_CYC;
      default:         win_len = `WIN_NONE_CYC;
    endcase
  endfunction : win_len

  wire [3:0] win_cyc = win_len(start_detect_window); // R4 R5 R8

  // sda changes only while scl is low; setup counted before scl rises is
  // enforced by holding busy so the master delays releasing scl
  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      st_q      <= smbus_timing_pkg::SDA_IDLE;
      cnt_q     <= 6'h0_0;
      sda_drv_q <= 1'b0;
    end else if (clk_en) begin
      unique case (st_q)
        smbus_timing_pkg::SDA_IDLE: begin
          if (scl_fall) begin
            st_q  <= smbus_timing_pkg::SDA_HOLD;
            cnt_q <= hold_cyc; // R2 R3
          end else if (sda_out_req != sda_drv_q && !scl_s_q) begin
            sda_drv_q <= sda_out_req;
            st_q      <= smbus_timing_pkg::SDA_SETUP;
            cnt_q     <= setup_cyc; // R2 R3
          end
        end
        smbus_timing_pkg::SDA_HOLD: begin
          if (cnt_q == 6'h0_1) st_q <= smbus_timing_pkg::SDA_IDLE;
          cnt_q <= cnt_q - 6'h0_1;
        end
        smbus_timing_pkg::SDA_SETUP: begin
          if (cnt_q == 6'h0_1) st_q <= smbus_timing_pkg::SDA_IDLE;
          cnt_q <= cnt_q - 6'h0_1;
        end
      endcase
    end
  end

  // sda fall with scl high waits out the window; an scl fall meanwhile
  // marks it a late data bit, not a start, at the cost of added latency
  wire start_cand = sda_fall & scl_s_q;

  always_ff @(posedge clk or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      win_q   <= 4'h0_0;
      pend_q  <= 1'b0;
      start_q <= 1'b0;
    end else if (clk_en) begin
      start_q <= 1'b0;
      if (pend_q) begin
        if (!scl_s_q) begin
          pend_q <= 1'b0; // R6
          win_q  <= 4'h0;
        end else if (win_q == 4'h1) begin
          pend_q  <= 1'b0;
          win_q   <= 4'h0;
          start_q <= 1'b1; // R5
        end else begin
          win_q <= win_q - 4'h1;
        end
      end else if (start_cand) begin
        if (win_cyc == 4'h0) start_q <= 1'b1; // R4
        else begin
          pend_q <= 1'b1;
          win_q  <= win_cyc; // R5 R8
        end
      end
    end
  end

  assign sda_oe_n   = ~sda_drv_q;
  assign sda_busy   = (st_q != smbus_timing_pkg::SDA_IDLE);
  assign start_seen = start_q;

  a_hold_len_std: assert property (@(posedge clk) disable iff (!rst_sync_q) // R2
    (clk_en && st_q == smbus_timing_pkg::SDA_IDLE && scl_fall && ext_on && !ext_long)
    |=> cnt_q == 6'h0_0C)
    else $error("standard hold count wrong");
  a_hold_len_ext: assert property (@(posedge clk) disable iff (!rst_sync_q) // R3
    (clk_en && st_q == smbus_timing_pkg::SDA_IDLE && scl_fall && ext_long)
    |=> cnt_q == 6'h0_1F)
    else $error("extended hold count wrong");
  a_select_gated: assert property (@(posedge clk) disable iff (!rst_sync_q) // R1
    (clk_en && st_q == smbus_timing_pkg::SDA_IDLE && scl_fall && !ext_on)
    |=> cnt_q == 6'h0_01)
    else $error("stretch select acted without enable");
  a_sda_stable_hold: assert property (@(posedge clk) disable iff (!rst_sync_q) // R2
    (st_q == smbus_timing_pkg::SDA_HOLD) |=> $stable(sda_oe_n))
    else $error("sda moved during hold");

  a_win_eight: assert property (@(posedge clk) disable iff (!rst_sync_q) // R5
    (clk_en && !pend_q && start_cand && start_detect_window == 2'h3)
    |=> (pend_q && win_q == 4'h8))
    else $error("eight cycle window not loaded");

  a_win_two: assert property (@(posedge clk) disable iff (!rst_sync_q) // R5
    (clk_en && !pend_q && start_cand && start_detect_window == 2'h1)
    |=> (pend_q && win_q == 4'h2))
    else $error("two cycle window not loaded");

  a_win_mid: assert property (@(posedge clk) disable iff (!rst_sync_q) // R8
    (clk_en && !pend_q && start_cand && start_detect_window == 2'h2)
    |=> (pend_q && win_q > 4'h2 && win_q < 4'h8))
    else $error("middle window out of range");

  a_no_false_start: assert property (@(posedge clk) disable iff (!rst_sync_q) // R6
    (clk_en && pend_q && !scl_s_q)
    |=> (!start_seen && !pend_q))
    else $error("start seen inside window");

  a_start_prompt: assert property (@(posedge clk) disable iff (!rst_sync_q) // R4
    (clk_en && !pend_q && start_cand && start_detect_window == 2'h0)
    |=> start_seen)
    else $error("start not flagged");

  a_start_late: assert property (@(posedge clk) disable iff (!rst_sync_q) // R5
    (clk_en && pend_q && scl_s_q && win_q == 4'h1)
    |=> start_seen)
    else $error("start not flagged after window");

  a_start_pulse: assert property (@(posedge clk) disable iff (!rst_sync_q) // R4
    (clk_en && start_seen)
    |=> !start_seen)
    else $error("start pulse longer than one cycle");

  a_setup_len_std: assert property (@(posedge clk) disable iff (!rst_sync_q) // R2
    (clk_en && st_q == smbus_timing_pkg::SDA_IDLE && !scl_fall && !scl_s_q
     && sda_out_req != sda_drv_q && ext_on && !ext_long) |=> cnt_q == 6'h0B)
    else $error("standard setup count wrong");

  a_setup_len_ext: assert property (@(posedge clk) disable iff (!rst_sync_q) // R3
    (clk_en && st_q == smbus_timing_pkg::SDA_IDLE && !scl_fall && !scl_s_q
     && sda_out_req != sda_drv_q && ext_long) |=> cnt_q == 6'h1F)
    else $error("extended setup count wrong");

  a_setup_gated: assert property (@(posedge clk) disable iff (!rst_sync_q) // R1
    (clk_en && st_q == smbus_timing_pkg::SDA_IDLE && !scl_fall && !scl_s_q
     && sda_out_req != sda_drv_q && !ext_on) |=> cnt_q == 6'h01)
    else $error("setup select acted without enable");

  a_sda_stable_setup: assert property (@(posedge clk) disable iff (!rst_sync_q) // R2
    (st_q == smbus_timing_pkg::SDA_SETUP)
    |=> $stable(sda_oe_n))
    else $error("sda moved during setup");

  a_oe_scl_low: assert property (@(posedge clk) disable iff (!rst_sync_q) // R2
    (clk_en && scl_s_q)
    |=> $stable(sda_oe_n))
    else $error("sda moved while scl high");

  a_busy_after_fall: assert property (@(posedge clk) disable iff (!rst_sync_q) // R2
    (clk_en && st_q == smbus_timing_pkg::SDA_IDLE && scl_fall)
    |=> sda_busy)
    else $error("hold not started on scl fall");
endmodule : smbus_setup_hold_start_window

/* verification/smbus_bus_partner.sv */
// other bus devices: pulled-up scl and sda lines
`timescale 1ns/1ps
module smbus_bus_partner (
  input  wire logic scl_run,
  input  wire logic scl_low,
  input  wire logic sda_low,
  input  wire logic dut_oe_n,
  output logic      scl,
  output logic      sda
);
  logic run_clk = 1'b1;
  // 48 ns link clock, parked high between frames
  always #24 run_clk = scl_run ? ~run_clk : 1'b1;
  assign scl = run_clk & ~scl_low;
  // open drain: pull-up wins unless someone drives low
  assign sda = dut_oe_n & ~sda_low;
endmodule : smbus_bus_partner

/* verification/smbus_setup_hold_start_window_tb.sv */
// self-checking bench for the setup/hold and start window block
`timescale 1ns/1ps
module smbus_setup_hold_start_window_tb;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       ext = 1'b0;
  logic       sel = 1'b0;
  logic [1:0] win = 2'h0;
  logic       req = 1'b0;
  logic       scl_run = 1'b0;
  logic       scl_low = 1'b0;
  logic       sda_low = 1'b0;
  logic       scl, sda, oe_n, busy, start;
  int         err_total = 0;
  int         tests_run = 0;
  int         cyc = 0;
  always #2.5 clk = ~clk;
  smbus_bus_partner i_bus (.scl_run(scl_run), .scl_low(scl_low), .sda_low(sda_low),
    .dut_oe_n(oe_n), .scl(scl), .sda(sda));
  smbus_setup_hold_start_window i_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .setup_hold_extension_enable(ext), .hold_delay_stretch_select(sel),
    .start_detect_window(win), .sda_out_req(req), .scl_in(scl), .sda_in(sda),
    .sda_oe_n(oe_n), .sda_busy(busy), .start_seen(start));
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
      err_total++;
    end
  endtask : check
  task automatic busy_len(output logic [7:0] n);
    n = 8'h00;
    for (int k = 0; k < 40 && busy !== 1'b1; k++) @(negedge clk);
    while (busy === 1'b1 && n < 8'h3F) begin
      n++;
      @(negedge clk);
    end
  endtask : busy_len
  // hold counted from scl fall, then setup after a new sda level
  task automatic t_timing(logic e, logic s, logic [7:0] su, logic [7:0] ho);
    logic [7:0] n;
    ext = e;
    sel = s;
    scl_low = 1'b0;
    repeat (40) @(negedge clk);
    scl_low = 1'b1;
    busy_len(n);
    check("hold", ho, n);
    req = ~req;
    busy_len(n);
    check("setup", su, n);
    repeat (3) @(negedge clk);
    check("sda_oe_n", {7'h00, ~req}, {7'h00, oe_n});
    $display("test timing %0d%0d done", e, s);
  endtask : t_timing
  // clean start, or sda falling one clock before scl falls (must not count)
  task automatic t_start(logic [1:0] w, logic skew);
    logic [7:0] n;
    logic [7:0] first;
    logic [7:0] lat;
    n = 8'h00;
    first = 8'h00;
    lat = 8'h03 + (w == 2'h1 ? 8'h02 : w == 2'h2 ? 8'h05 : w == 2'h3 ? 8'h08 : 8'h00);
    win = w;
    req = 1'b0;
    repeat (40) @(negedge clk);
    scl_low = 1'b0;
    repeat (20) @(negedge clk);
    sda_low = 1'b1;
    if (skew) @(negedge clk);
    scl_low = skew;
    for (int k = 1; k <= 20; k++) begin
      @(negedge clk);
      if (start === 1'b1) begin
        n++;
        if (first == 8'h00) first = k[7:0];
      end
    end
    check("start_seen", {7'h00, ~skew}, n);
    if (!skew) check("start_delay", lat, first);
    sda_low = 1'b0;
    $display("test start %0d %0d done", w, skew);
  endtask : t_start
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    logic [7:0] n;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check("oe_n reset", 8'h01, {7'h00, oe_n});
    t_timing(1'b0, 1'b1, 8'h01, 8'h01);
    t_timing(1'b1, 1'b0, 8'h0B, 8'h0C);
    t_timing(1'b1, 1'b1, 8'h1F, 8'h1F);
    for (int w = 0; w < 4; w++) t_start(w[1:0], 1'b0);
    for (int w = 1; w < 4; w++) t_start(w[1:0], 1'b1);
    n = 8'h00;
    scl_low = 1'b0;
    scl_run = 1'b1;
    repeat (200) begin
      @(negedge clk);
      if (start === 1'b1) n++;
    end
    scl_run = 1'b0;
    check("no start while clocking", 8'h00, n);
    report_and_stop();
  end
endmodule : smbus_setup_hold_start_window_tb
